// ===== spi_port_map.svh
`ifndef SPI_PORT_MAP_SVH
`define SPI_PORT_MAP_SVH
// Register byte offsets
`define REG_CTRL_OFF      8'h00
`define REG_STATUS_OFF    8'h04
`define REG_BUF_OFF       8'h08
`define REG_DIV_OFF       8'h0C
// Control fields
`define CTRL_EN_BIT       0
`define CTRL_MASTER_BIT   1
`define CTRL_CPOL_BIT     2
`define CTRL_CPHA_BIT     3
`define CTRL_SSEN_BIT     4
`define CTRL_BOEN_BIT     5
`define CTRL_RATE_LSB     6
`define CTRL_RATE_MSB     8
// Status fields
`define STAT_FULL_BIT     0
`define STAT_EVENT_BIT    1
`define STAT_WRITE_COLLISION_FLAG_BIT     2
`define STAT_BUSY_BIT     3
`define STAT_OVF_BIT      4
// Reset values
`define CTRL_RESET        9'h000
`define DIV_RESET         8'h00
`define BUF_RESET         8'h00
// Timing counts, in system clocks per half bit, and bits per byte
`define HALF_DIV4         8'h02
`define HALF_DIV16        8'h08
`define HALF_DIV64        8'h20
`define BITS_PER_BYTE     4'h8
`endif

// ===== spi_port_pkg.sv
`default_nettype none
package spi_port_pkg;
    typedef enum logic [2:0] {
        RATE_DIV4  = 3'h0,
        RATE_DIV16 = 3'h1,
        RATE_DIV64 = 3'h2,
        RATE_TMR   = 3'h3,
        RATE_DIVN  = 3'h4
    } rate_sel_e;

    typedef struct packed {
        rate_sel_e  rate;
        logic       boen;
        logic       ssen;
        logic       cpha;
        logic       cpol;
        logic       master;
        logic       en;
    } ctrl_s;

    typedef struct packed {
        logic       sck;
        logic       sdo;
        logic       sdi;
        logic       ss_n;
    } pins_in_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_TRAIL = 2'b11
    } master_st_e;
endpackage : spi_port_pkg
`default_nettype wire

// ===== spi_port_shift_exchange.sv
`default_nettype none
`include "spi_port_map.svh"
module spi_port_shift_exchange
    import spi_port_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        tmr_match,
    input  wire logic        serial_clock_line_i,
    output logic             serial_clock_line_o,
    output logic             serial_clock_line_oe_n,
    input  wire logic        serial_data_input,
    output logic             serial_data_output,
    output logic             serial_data_output_oe_n,
    input  wire logic        target_select_line_n
);
    // Pin synchronisers: first stage read only by the second
    pins_in_s    meta_r;
    pins_in_s    sync_r;
    logic        sck_d_r;

    ctrl_s       ctrl_r;
    logic [7:0]  div_r;
    logic [7:0]  buf_r;
    logic [7:0]  link_shift_register_r;
    logic [3:0]  bit_cnt_r;
    logic        receive_full_flag_r;
    logic        port_event_flag_r;
    logic        write_collision_flag_r;
    logic        overflow_r;
    logic        busy_r;
    logic        in_bit_r;
    logic        sck_out_r;
    logic        sck_oe_n_r;
    logic        sdo_r;
    logic        sdo_oe_n_r;
    logic [8:0]  half_cnt_r;
    master_st_e  mst_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_r  <= '0;
            sync_r  <= '0;
            sck_d_r <= 1'b0;
        end else begin
            meta_r  <= {serial_clock_line_i, 1'b0, serial_data_input,
                        target_select_line_n};
            sync_r  <= meta_r;
            sck_d_r <= sync_r.sck;
        end
    end

    // Bus decode
    wire        bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
    wire [7:0]  bus_off   = wb_adr_i[7:0];
    wire        hit_ctrl  = bus_off == `REG_CTRL_OFF;
    wire        hit_stat  = bus_off == `REG_STATUS_OFF;
    wire        hit_buf   = bus_off == `REG_BUF_OFF;
    wire        hit_div   = bus_off == `REG_DIV_OFF;
    wire        wr_ctrl   = bus_wr & hit_ctrl;
    wire        wr_stat   = bus_wr & hit_stat;
    wire        wr_div    = bus_wr & hit_div;
    wire        wr_buf    = bus_wr & hit_buf;
    wire        rd_buf    = bus_req & ~wb_we_i & hit_buf;
    wire        is_master = ctrl_r.en & ctrl_r.master;
    wire        is_target = ctrl_r.en & ~ctrl_r.master;
    // Without select sync the target is always considered selected
    wire        selected  = ~ctrl_r.ssen | ~sync_r.ss_n;
    wire        tgt_act   = is_target & selected;
    // Collision blocks the write until software clears it
    wire        buf_block = busy_r | write_collision_flag_r
                            | (receive_full_flag_r & ~ctrl_r.boen);
    wire        buf_load  = wr_buf & ctrl_r.en & ~buf_block;
    wire        collide   = wr_buf & ctrl_r.en & busy_r;

    wire [31:0] stat_word = {27'h0, overflow_r, busy_r,
                             write_collision_flag_r, port_event_flag_r,
                             receive_full_flag_r};
    wire [31:0] rd_mux    = hit_ctrl ? {23'h0, ctrl_r} :
                            hit_stat ? stat_word :
                            hit_buf  ? {24'h0, buf_r} :
                            hit_div  ? {24'h0, div_r} : 32'h0;

    // Master bit timing
    wire [8:0]  half_lim  =
        ctrl_r.rate == RATE_DIV16 ? {1'b0, `HALF_DIV16} :
        ctrl_r.rate == RATE_DIV64 ? {1'b0, `HALF_DIV64} :
        ctrl_r.rate == RATE_DIVN  ? {div_r, 1'b0} + 9'h002 :
                                    {1'b0, `HALF_DIV4};
    wire        half_tick = ctrl_r.rate == RATE_TMR ? tmr_match :
                            (half_cnt_r == half_lim - 9'h001);
    // Each timer match is one half bit, so the clock is match rate / 2
    wire        tmr_half  = half_tick;

    // Target edges from synchronised pin; edge sense follows cpol
    wire        sck_rise  = sync_r.sck & ~sck_d_r;
    wire        sck_fall  = ~sync_r.sck & sck_d_r;
    wire        lead_edge = ctrl_r.cpol ? sck_fall : sck_rise;
    wire        trail_edge = ctrl_r.cpol ? sck_rise : sck_fall;
    // cpha=0: capture on leading, shift on trailing; cpha=1 opposite
    wire        m_lead    = mst_r == ST_LEAD & tmr_half;
    wire        m_trail   = mst_r == ST_TRAIL & tmr_half;
    wire        cap_ev    = is_master ? (ctrl_r.cpha ? m_trail : m_lead)
                          : tgt_act & (ctrl_r.cpha ? trail_edge : lead_edge);
    wire        shf_ev    = is_master ? (ctrl_r.cpha ? m_lead : m_trail)
                          : tgt_act & (ctrl_r.cpha ? lead_edge : trail_edge);
    wire        last_bit  = bit_cnt_r == `BITS_PER_BYTE - 4'h1;
    // Byte ends on the second edge of the eighth clock, or of the seventh clock when cpha=1
    wire        end_ev    = is_master ? m_trail & last_bit
                          : tgt_act & trail_edge & last_bit;
    // Master takes its bit at the shift edge straight from the synchroniser:
    // it then shows the pin two clocks back, still inside the capture half,
    // which keeps the fastest rate exact despite the pin latency
    wire        in_pick   = is_master ? sync_r.sdi : in_bit_r;
    wire [7:0]  shifted   = {link_shift_register_r[6:0], in_pick};

    always_ff @(posedge sys_clk) begin
        wb_ack_o <= ~srst & bus_req;
        wb_dat_o <= srst ? 32'h0 : rd_mux;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r <= `CTRL_RESET;
            div_r  <= `DIV_RESET;
        end else begin
            if (wr_ctrl)
                ctrl_r <= wb_dat_i[`CTRL_RATE_MSB:0];
            if (wr_div)
                div_r <= wb_dat_i[7:0];
        end
    end

    // Flags: hardware set wins over software clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            receive_full_flag_r    <= 1'b0;
            port_event_flag_r      <= 1'b0;
            write_collision_flag_r <= 1'b0;
            overflow_r             <= 1'b0;
        end else begin
            receive_full_flag_r <= end_ev | (receive_full_flag_r & ~rd_buf);
            port_event_flag_r   <= end_ev | (port_event_flag_r
                                   & ~(wr_stat & wb_dat_i[`STAT_EVENT_BIT]));
            write_collision_flag_r <= collide | (write_collision_flag_r
                                   & ~(wr_stat & wb_dat_i[`STAT_WRITE_COLLISION_FLAG_BIT]));
            overflow_r <= (end_ev & receive_full_flag_r & ~rd_buf)
                          | (overflow_r
                             & ~(wr_stat & wb_dat_i[`STAT_OVF_BIT]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            buf_r                 <= `BUF_RESET;
            link_shift_register_r <= `BUF_RESET;
            bit_cnt_r             <= 4'h0;
            in_bit_r              <= 1'b0;
            busy_r                <= 1'b0;
        end else if (!ctrl_r.en) begin
            bit_cnt_r <= 4'h0;
            busy_r    <= 1'b0;
        end else begin
            if (buf_load) begin
                buf_r                 <= wb_dat_i[7:0];
                link_shift_register_r <= wb_dat_i[7:0];
                bit_cnt_r             <= 4'h0;
                busy_r                <= is_master;
            end else if (end_ev) begin
                buf_r                 <= shifted;
                link_shift_register_r <= shifted;
                bit_cnt_r             <= 4'h0;
                busy_r                <= 1'b0;
            end else if (shf_ev) begin
                link_shift_register_r <= shifted;
                bit_cnt_r             <= bit_cnt_r + 4'h1;
            end
            if (cap_ev)
                in_bit_r <= sync_r.sdi;
            // Target is busy from first captured bit of a byte
            if (!is_master && cap_ev && !buf_load)
                busy_r <= 1'b1;
        end
    end

    // Master clock generator and pin drivers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mst_r      <= ST_IDLE;
            half_cnt_r <= 9'h000;
            sck_out_r  <= 1'b0;
        end else begin
            half_cnt_r <= (half_tick || mst_r == ST_IDLE) ? 9'h000
                          : half_cnt_r + 9'h001;
            case (mst_r)
                ST_IDLE: begin
                    sck_out_r <= ctrl_r.cpol;
                    if (buf_load && is_master)
                        mst_r <= ST_LEAD;
                end
                ST_LEAD: begin
                    if (!is_master)
                        mst_r <= ST_IDLE;
                    else if (tmr_half) begin
                        sck_out_r <= ~ctrl_r.cpol;
                        mst_r     <= ST_TRAIL;
                    end
                end
                ST_TRAIL: begin
                    if (!is_master)
                        mst_r <= ST_IDLE;
                    else if (tmr_half) begin
                        sck_out_r <= ctrl_r.cpol;
                        mst_r <= last_bit ? ST_IDLE : ST_LEAD;
                    end
                end
                default: mst_r <= ST_IDLE;
            endcase
        end
    end

    // Data out shows current MSB; floats when target unselected
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sck_oe_n_r <= 1'b1;
            sdo_r      <= 1'b0;
            sdo_oe_n_r <= 1'b1;
        end else begin
            sck_oe_n_r <= ~is_master;
            // First bit shows at once, ahead of a timer tick on the next edge
            sdo_r      <= buf_load ? wb_dat_i[7]
                          : link_shift_register_r[7];
            sdo_oe_n_r <= ~(is_master | tgt_act);
        end
    end

    assign serial_clock_line_o     = sck_out_r;
    assign serial_clock_line_oe_n  = sck_oe_n_r;
    assign serial_data_output      = sdo_r;
    assign serial_data_output_oe_n = sdo_oe_n_r;
endmodule : spi_port_shift_exchange
`default_nettype wire

// ===== spi_port_checker.sv
`default_nettype none
`include "spi_port_map.svh"
module spi_port_checker
    import spi_port_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        serial_clock_line_o,
    input wire logic        serial_clock_line_oe_n,
    input wire logic        serial_data_output_oe_n,
    input wire logic        target_select_line_n
);
    ctrl_s ctrl_r;
    wire logic ctrl_wr = wb_ack_o && wb_we_i && wb_sel_i[0]
                         && wb_adr_i[7:0] == `REG_CTRL_OFF;
    wire logic mst = ctrl_r.en && ctrl_r.master;
    wire logic tgt = ctrl_r.en && !ctrl_r.master && ctrl_r.ssen;
    wire logic slow = ctrl_r.rate != RATE_TMR;

    // Shadow of the control register, so rules can be tied to the mode
    always_ff @(posedge sys_clk) begin
        if (srst) ctrl_r <= ctrl_s'(9'h000);
        else if (ctrl_wr) ctrl_r <= ctrl_s'(wb_dat_i[8:0]);
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_reset_quiet: assert property ($fell(srst) |-> !wb_ack_o
        && serial_clock_line_oe_n && serial_data_output_oe_n)
        else $error("pins driven straight after reset");
    a_idle_polarity: assert property (ctrl_wr ##1 mst [*3] |->
        serial_clock_line_o == ctrl_r.cpol && !serial_clock_line_oe_n)
        else $error("master clock not idle at polarity");
    a_target_float: assert property ((tgt && target_select_line_n) [*5]
        |-> serial_data_output_oe_n)
        else $error("unselected target drives data");
    a_target_no_clk: assert property ((!ctrl_r.master) [*3]
        |-> serial_clock_line_oe_n)
        else $error("clock driven outside master mode");
    a_half_bit_min: assert property ($rose(serial_clock_line_o)
        && slow && !serial_clock_line_oe_n |-> !$past(serial_clock_line_o, 2))
        else $error("clock half period below two cycles");

    c_ctrl_write: cover property (ctrl_wr);
    c_clock_rise: cover property ($rose(serial_clock_line_o));
    c_target_off: cover property ((tgt && target_select_line_n) [*5]);
endmodule : spi_port_checker
`default_nettype wire

// ===== spi_far_target.sv
`default_nettype none
module spi_far_target (
    input wire logic       sclk,
    input wire logic       mosi,
    output logic           miso,
    input wire logic       load,
    input wire logic [7:0] load_byte,
    output logic     [7:0] got_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh_r = 8'h00;
    logic       in_r = 1'b0;

    always @(posedge load) sh_r = load_byte;
    always @(posedge sclk) in_r = mosi;
    always @(negedge sclk) sh_r = {sh_r[6:0], in_r};
    assign miso = sh_r[7];
    assign got_byte = sh_r;
endmodule : spi_far_target
`default_nettype wire

// ===== spi_port_shift_exchange_tb.sv
`default_nettype none
`include "spi_port_map.svh"
module spi_port_shift_exchange_tb;
    import spi_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, srst = 1, we = 0, cyc = 0, stb = 0;
    logic [31:0] adr = 0, wdat = 0, rdat;
    logic        ack, sck_o, sck_oe_n, dout, dout_oe_n, far_out;
    logic        tb_sck = 0, tb_din = 0, sel_n = 1, ext = 0, ld = 0;
    logic [7:0]  ld_byte = 0, far_byte;
    wire logic   din = ext ? tb_din : far_out;
    int          n_mismatch = 0, total_checks = 0, n_pulse = 0;
    time         t_rise = 0, per = 0;
    logic        tmr = 0;
    logic [2:0]  tmr_cnt = 0;

    always #10 sys_clk = ~sys_clk;
    // Timer match every five system clocks
    always @(posedge sys_clk) begin
        tmr_cnt <= (tmr_cnt == 3'h4) ? 3'h0 : tmr_cnt + 3'h1;
        tmr     <= tmr_cnt == 3'h4;
    end
    always @(posedge sck_o) begin
        per = $time - t_rise;
        t_rise = $time;
        n_pulse++;
    end

    spi_port_shift_exchange u_spi_port_shift_exchange (
        .sys_clk(sys_clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_ack_o(ack), .tmr_match(tmr),
        .serial_clock_line_i(tb_sck), .serial_clock_line_o(sck_o),
        .serial_clock_line_oe_n(sck_oe_n), .serial_data_input(din),
        .serial_data_output(dout), .serial_data_output_oe_n(dout_oe_n),
        .target_select_line_n(sel_n));
    spi_far_target u_spi_far_target (.sclk(sck_o), .mosi(dout),
        .miso(far_out), .load(ld), .load_byte(ld_byte), .got_byte(far_byte));

    task automatic chk(input string what, input logic [31:0] e, q);
        total_checks++;
        if (q !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, q);
        end
    endtask : chk
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        {cyc, stb, we} <= {2'b11, w};
        adr <= {24'h0, a};
        wdat <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask : rd_chk
    task automatic wait_idle;
        logic [31:0] q;
        q = 32'h8;
        while (q[`STAT_BUSY_BIT] !== 1'b0) bus(1'b0, `REG_STATUS_OFF, 0, q);
    endtask : wait_idle
    task automatic load_far(input logic [7:0] b);
        @(posedge sys_clk);
        {ld, ld_byte} <= {1'b1, b};
        @(posedge sys_clk);
        ld <= 1'b0;
    endtask : load_far
    task automatic t_regs;
        wr(8'h10, 32'hFF);
        rd_chk("unmapped", 8'h10, 32'h0);
        rd_chk("status", `REG_STATUS_OFF, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_xfer(input logic [2:0] r, input logic [7:0] dv, tx, rx,
                          input time e_per);
        wr(`REG_DIV_OFF, {24'h0, dv});
        wr(`REG_CTRL_OFF, {23'h0, r, 6'h03});
        load_far(rx);
        n_pulse = 0;
        wr(`REG_BUF_OFF, {24'h0, tx});
        wait_idle();
        rd_chk("status", `REG_STATUS_OFF, 32'h3);
        rd_chk("rx byte", `REG_BUF_OFF, {24'h0, rx});
        chk("far byte", {24'h0, tx}, {24'h0, far_byte});
        chk("pulses", 8, n_pulse);
        chk("bit period", e_per, per);
        wr(`REG_STATUS_OFF, 32'h2);
        $display("test xfer rate %0d done", r);
    endtask : t_xfer
    task automatic t_collide;
        load_far(8'h5A);
        wr(`REG_BUF_OFF, 32'h81);
        rd_chk("busy", `REG_STATUS_OFF, 32'h8);
        wr(`REG_BUF_OFF, 32'hFF);
        wait_idle();
        rd_chk("status", `REG_STATUS_OFF, 32'h7);
        rd_chk("rx byte", `REG_BUF_OFF, 32'h5A);
        chk("far byte", 32'h81, {24'h0, far_byte});
        wr(`REG_STATUS_OFF, 32'h6);
        rd_chk("cleared", `REG_STATUS_OFF, 32'h0);
        $display("test collide done");
    endtask : t_collide
    task automatic ext_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            tb_din <= tx[i];
            repeat (6) @(posedge sys_clk);
            rx[i] = dout;
            tb_sck <= 1'b1;
            repeat (6) @(posedge sys_clk);
            tb_sck <= 1'b0;
        end
        tb_din <= ~tx[0];
    endtask : ext_byte
    task automatic t_target;
        logic [7:0] got;
        ext <= 1'b1;
        wr(`REG_CTRL_OFF, 32'h11);
        wr(`REG_BUF_OFF, 32'h6B);
        ext_byte(8'hFF, got);
        chk("float", 32'h1, {31'h0, dout_oe_n});
        rd_chk("ignored", `REG_STATUS_OFF, 32'h0);
        sel_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        ext_byte(8'h2D, got);
        repeat (6) @(posedge sys_clk);
        sel_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("target out", 32'h6B, {24'h0, got});
        rd_chk("target in", `REG_BUF_OFF, 32'h2D);
        $display("test target done");
    endtask : t_target
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        t_regs();
        t_xfer(RATE_DIV4, 8'h00, 8'h3C, 8'hA5, 80);
        t_xfer(RATE_DIV16, 8'h00, 8'h96, 8'hC3, 320);
        t_xfer(RATE_DIV64, 8'h00, 8'h01, 8'h80, 1280);
        t_xfer(RATE_TMR, 8'h00, 8'h5C, 8'h3A, 200);
        t_xfer(RATE_DIVN, 8'h02, 8'hE7, 8'h18, 240);
        t_collide();
        t_target();
        print_verdict();
    end
    initial begin
        #400000;
        n_mismatch++;
        $display("[ERR] watchdog expired");
        print_verdict();
    end
endmodule : spi_port_shift_exchange_tb

bind spi_port_shift_exchange spi_port_checker u_spi_port_checker (
    .sys_clk(sys_clk), .srst(srst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .serial_clock_line_o(serial_clock_line_o),
    .serial_clock_line_oe_n(serial_clock_line_oe_n),
    .serial_data_output_oe_n(serial_data_output_oe_n),
    .target_select_line_n(target_select_line_n));
`default_nettype wire
